// >>> rtl/spc_pkg.sv
/*
  Constants for the serial-link coding channel: register map, control and
  status fields, 8b/10b code tables and compensation thresholds.
  Assumes a 32-bit AXI4-Lite register bus and one channel per instance.
*/
package spc_pkg;

  // ********************************
  // register map
  // ********************************
  localparam int ADDR_W = 4;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STAT = 4'h4;
  localparam logic [3:0] ADDR_SLIP = 4'h8;
  localparam logic [3:0] ADDR_ERRS = 4'hc;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // ********************************
  // control and status fields
  // ********************************
  localparam int CB_RXINV = 0;
  localparam int CB_TXINV = 1;
  localparam int CB_BYP = 2;
  localparam int CB_W10 = 3;
  localparam int CB_HALF = 4;
  localparam int CB_ALIGN = 5;
  localparam int CB_CTC = 6;
  localparam int CB_SDI = 7;
  localparam logic [7:0] CTRL_RST = 8'h68;
  localparam int ST_ALIGNED = 0;
  localparam int ST_EMPTY = 1;
  localparam int ST_LANES = 8;
  localparam int ST_RATE = 16;
  localparam logic [15:0] LINE_RATE_MBPS = 16'h09c4;
  localparam int LANES_DEF = 1;

  // ********************************
  // code tables, negative running disparity
  // ********************************
  localparam logic [5:0] ENC6 [32] = '{
    6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
    6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17,
    6'h1b, 6'h23, 6'h13, 6'h32, 6'h0b, 6'h2a, 6'h1a, 6'h3a,
    6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b};
  localparam logic [3:0] ENC4 [8] = '{
    4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, 4'he};
  localparam logic [3:0] ALT7 = 4'h7;
  localparam logic [5:0] K28_6 = 6'h0f;
  localparam logic [5:0] D07_POS = 6'h07;
  localparam logic [6:0] COMMA_N = 7'h1f;
  localparam logic [6:0] COMMA_P = 7'h60;
  localparam logic [7:0] SKIP_B = 8'h1c;

  // ********************************
  // down-sample FIFO
  // ********************************
  localparam int FIFO_AW = 3;
  localparam int CTC_HI = 6;
  localparam int CTC_LO = 2;

endpackage

// >>> rtl/spc_pcs_channel.sv
/*
  One serial-link coding channel: receive polarity, word alignment with
  bit slip, 8b/10b decode, skip compensation and a down-sample FIFO into
  sys_clk; transmit encode and polarity; AXI4-Lite control registers.
  Assumes rxClk is the recovered clock of the deserializer feeding
  rxWordIn, and the serializer takes txWord on sys_clk.
*/
`timescale 1ns/100ps

module spc_pcs_channel
  import spc_pkg::*;
#(
  parameter int LANES = LANES_DEF,
  parameter int FAW = FIFO_AW,
  parameter logic [7:0] CTRL_INIT = CTRL_RST
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic rxClk,
  input wire logic [9:0] rxWordIn,
  output logic rxClkMon,
  output logic txClkMon,
  output logic [9:0] txWord,
  input wire logic [19:0] txData,
  input wire logic [1:0] txK,
  output logic txReady,
  output logic [19:0] rxData,
  output logic [1:0] rxK,
  output logic [1:0] rxErr,
  output logic rxValid,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ********************************
  // 8b/10b coding, word = abcdei fghj
  // ********************************
  function automatic logic [10:0] enc(input logic [7:0] d,
                                      input logic k, input logic rd);
    logic [5:0] s;
    logic [3:0] f;
    logic r;
    s = (k && d[4:0] == 5'd28) ? K28_6 : ENC6[d[4:0]];
    if (rd && ($countones(s) != 3 || s == ENC6[7]))
      s = ~s;
    r = ($countones(s) == 3) ? rd : ~rd;
    f = ENC4[d[7:5]];
    if (d[7:5] == 3'd7 && (k || (r ? s[1:0] == 2'b00 : &s[1:0])))
      f = ALT7;
    if (r && ($countones(f) != 2 || f == ENC4[3]))
      f = ~f;
    // balanced K28 tails flip with the head, unlike data tails
    if (k && !r && $countones(f) == 2 && f != ENC4[3])
      f = ~f;
    enc = {($countones(f) == 2) ? r : ~r, s, f};
  endfunction

  // returns {rd, err, k, byte}; unknown groups decode as zero
  function automatic logic [10:0] dec(input logic [9:0] c,
                                      input logic rd);
    logic [5:0] s;
    logic [3:0] f;
    logic [4:0] x;
    logic [2:0] y;
    logic h6, h4, kk, bad, r;
    logic [3:0] fd;
    s = c[9:4];
    f = c[3:0];
    x = 5'd0;
    y = 3'd0;
    h6 = 1'b0;
    h4 = 1'b0;
    for (int i = 0; i < 32; i++)
      if (s == ENC6[i] || (s == ~ENC6[i] && $countones(ENC6[i]) != 3)
          || (i == 7 && s == D07_POS))
      begin
        x = 5'(i);
        h6 = 1'b1;
      end
    kk = (s == K28_6 || s == ~K28_6);
    if (kk)
      x = 5'd28;
    // a positive K28 head carries a flipped balanced tail
    fd = (s == ~K28_6 && $countones(f) == 2 && f != ENC4[3]
      && f != ~ENC4[3]) ? ~f : f;
    for (int j = 0; j < 8; j++)
      if (fd == ENC4[j] || (fd == ~ENC4[j] && $countones(ENC4[j]) != 2)
          || (j == 3 && fd == ~ENC4[3]) || (j == 7 && (fd == ALT7
          || fd == ~ALT7)))
      begin
        y = 3'(j);
        h4 = 1'b1;
      end
    bad = !(h6 || kk) || !h4;
    r = rd;
    if ($countones(s) == 4 && r || $countones(s) == 2 && !r)
      bad = 1'b1;
    // an unbalanced block sets the disparity, so a bad group or a
    // boundary change cannot leave the tracker inverted for good
    if ($countones(s) != 3)
      r = $countones(s) > 3;
    if ($countones(f) == 3 && r || $countones(f) == 1 && !r)
      bad = 1'b1;
    if ($countones(f) != 2)
      r = $countones(f) > 2;
    dec = {r, bad, kk, y, x};
  endfunction

  function automatic logic [FAW:0] g2b(input logic [FAW:0] g);
    for (int i = 0; i <= FAW; i++)
      g2b[i] = ^(g >> i);
  endfunction

  // ********************************
  // register bus
  // ********************************
  logic [7:0] ctrl_r;
  logic [15:0] errCnt_r;
  logic slipTgl_r;
  logic awHave_r, wHave_r, wStrb0_r;
  logic [ADDR_W-1:0] awAddr_r;
  logic [31:0] wData_r;
  logic alignS1_r, alignS2_r;
  logic rEmpty;
  logic popErr;

  wire awTake = s_axi_awvalid && s_axi_awready;
  wire wTake = s_axi_wvalid && s_axi_wready;
  wire doWrite = awHave_r && wHave_r && !s_axi_bvalid;
  wire awHave_nxt = awTake || (awHave_r && !doWrite);
  wire wHave_nxt = wTake || (wHave_r && !doWrite);
  wire bDone = s_axi_bvalid && s_axi_bready;
  wire wrCtrl = doWrite && awAddr_r == ADDR_CTRL && wStrb0_r;
  wire wrSlip = doWrite && awAddr_r == ADDR_SLIP && wStrb0_r;
  wire wrErrs = doWrite && awAddr_r == ADDR_ERRS;
  wire wrMapped = awAddr_r == ADDR_CTRL || awAddr_r == ADDR_SLIP
    || awAddr_r == ADDR_ERRS;
  wire arTake = s_axi_arvalid && s_axi_arready;
  wire rvalid_nxt = arTake || (s_axi_rvalid && !s_axi_rready);
  wire [31:0] statWord = {LINE_RATE_MBPS, 5'h00, 3'(LANES), 6'h00,
    rEmpty, alignS2_r};
  wire rdMapped = s_axi_araddr == ADDR_CTRL || s_axi_araddr == ADDR_STAT
    || s_axi_araddr == ADDR_ERRS || s_axi_araddr == ADDR_SLIP;
  wire [31:0] rdMux =
    s_axi_araddr == ADDR_CTRL ? {24'h000000, ctrl_r} :
    s_axi_araddr == ADDR_STAT ? statWord :
    s_axi_araddr == ADDR_ERRS ? {16'h0000, errCnt_r} : 32'h00000000;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      awHave_r <= 1'b0;
      wHave_r <= 1'b0;
      awAddr_r <= '0;
      wData_r <= 32'h00000000;
      wStrb0_r <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else
    begin
      awHave_r <= awHave_nxt;
      wHave_r <= wHave_nxt;
      s_axi_awready <= !awHave_nxt;
      s_axi_wready <= !wHave_nxt;
      if (awTake)
        awAddr_r <= s_axi_awaddr;
      if (wTake)
      begin
        wData_r <= s_axi_wdata;
        wStrb0_r <= s_axi_wstrb[0];
      end
      if (doWrite)
        s_axi_bresp <= wrMapped ? RESP_OKAY : RESP_DECERR;
      s_axi_bvalid <= doWrite || (s_axi_bvalid && !bDone);
    end
  end

  // configuration comes up from CTRL_INIT and may be rewritten live
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      ctrl_r <= CTRL_INIT;
      slipTgl_r <= 1'b0;
      errCnt_r <= 16'h0000;
    end
    else
    begin
      if (wrCtrl)
        ctrl_r <= wData_r[7:0];
      if (wrSlip && wData_r[0])
        slipTgl_r <= ~slipTgl_r;
      // a new error in the clearing cycle is still counted
      if (popErr)
        errCnt_r <= wrErrs ? 16'h0001 : errCnt_r + 16'h0001;
      else if (wrErrs)
        errCnt_r <= 16'h0000;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !rvalid_nxt;
      s_axi_rvalid <= rvalid_nxt;
      if (arTake)
      begin
        s_axi_rdata <= rdMux;
        s_axi_rresp <= rdMapped ? RESP_OKAY : RESP_DECERR;
      end
    end
  end

  // ********************************
  // receive side, recovered clock
  // ********************************
  logic rxRst1_r, rxRst2_r;
  logic [7:0] ctrlR1_r, ctrlMid_r, ctrlChk_r, ctrlR2_r;
  logic slip1_r, slip2_r, slip3_r;
  logic [19:0] win_r;
  logic [3:0] off_r, hitOff;
  logic hitAny, rxAlign_r, rd_r;
  logic [9:0] commaAt;
  logic [FAW:0] wBin_r, wGray_r, rgW1_r, rgW2_r, rBin_r, rGray_r;
  logic [11:0] mem [2**FAW];

  always_ff @(posedge rxClk)
  begin
    rxRst1_r <= rst;
    rxRst2_r <= rxRst1_r;
    ctrlR1_r <= ctrl_r;
    ctrlMid_r <= ctrlR1_r;
    ctrlChk_r <= ctrlMid_r;
    // a multi-bit word: take it only once two samples agree
    if (ctrlMid_r == ctrlChk_r)
      ctrlR2_r <= ctrlMid_r;
    slip1_r <= slipTgl_r;
    slip2_r <= slip1_r;
    slip3_r <= slip2_r;
    rgW1_r <= rGray_r;
    rgW2_r <= rgW1_r;
  end

  wire rxRst = rxRst2_r;
  wire slipEv = slip2_r ^ slip3_r;
  wire sdiR = ctrlR2_r[CB_SDI];
  wire bypR = ctrlR2_r[CB_BYP] || sdiR;
  wire [9:0] wMask = ctrlR2_r[CB_W10] ? 10'h3ff : 10'h0ff;
  wire [9:0] polW = (ctrlR2_r[CB_RXINV] ? ~rxWordIn : rxWordIn)
    & wMask;

  generate
    for (genvar i = 0; i < 10; i++)
    begin : g_comma
      assign commaAt[i] = win_r[19-i -: 7] == COMMA_N
        || win_r[19-i -: 7] == COMMA_P;
    end
  endgenerate

  always_comb
  begin
    hitAny = 1'b0;
    hitOff = 4'h0;
    for (int i = 9; i >= 0; i--)
      if (commaAt[i])
      begin
        hitAny = 1'b1;
        hitOff = 4'(i);
      end
  end

  wire [3:0] offStep = (off_r == 4'd9) ? 4'd0 : off_r + 4'd1;
  wire [3:0] off_nxt = sdiR ? 4'd0 : slipEv ? offStep :
    (ctrlR2_r[CB_ALIGN] && !bypR && hitAny) ? hitOff : off_r;
  wire [9:0] alW = win_r[5'd19 - {1'b0, off_r} -: 10];
  wire [10:0] decW = dec(alW, rd_r);
  wire [11:0] entry = bypR ? {2'b00, alW} :
    {decW[9], decW[8], 2'b00, decW[7:0]};
  wire isSkip = !bypR && decW[8] && decW[7:0] == SKIP_B;
  wire [FAW:0] fillW = wBin_r - g2b(rgW2_r);
  wire wFull = wGray_r == {~rgW2_r[FAW:FAW-1], rgW2_r[FAW-2:0]};
  wire dropSkip = isSkip && ctrlR2_r[CB_CTC]
    && fillW >= (FAW+1)'(CTC_HI);
  wire wEn = !rxRst && !wFull && !dropSkip;
  wire [FAW:0] wBin_nxt = wBin_r + (FAW+1)'(1);

  always_ff @(posedge rxClk)
  begin
    if (rxRst)
    begin
      win_r <= 20'h00000;
      off_r <= 4'h0;
      rxAlign_r <= 1'b0;
      rd_r <= 1'b0;
      wBin_r <= '0;
      wGray_r <= '0;
      rxClkMon <= 1'b0;
    end
    else
    begin
      win_r <= {win_r[9:0], polW};
      off_r <= off_nxt;
      rxAlign_r <= (hitAny && hitOff == off_nxt) || (rxAlign_r && !slipEv);
      if (!bypR)
        rd_r <= decW[10];
      if (wEn)
      begin
        wBin_r <= wBin_nxt;
        wGray_r <= wBin_nxt ^ (wBin_nxt >> 1);
      end
      rxClkMon <= ~rxClkMon;
    end
  end

  // the array is written only here and read only on sys_clk
  always_ff @(posedge rxClk)
  begin
    if (wEn)
      mem[wBin_r[FAW-1:0]] <= entry;
  end

  // ********************************
  // fabric side of the receive FIFO
  // ********************************
  logic [FAW:0] wgR1_r, wgR2_r;
  logic rxPh_r;

  always_ff @(posedge sys_clk)
  begin
    wgR1_r <= wGray_r;
    wgR2_r <= wgR1_r;
    alignS1_r <= rxAlign_r;
    alignS2_r <= alignS1_r;
  end

  wire half = ctrl_r[CB_HALF];
  wire ctcOn = ctrl_r[CB_CTC] && !ctrl_r[CB_BYP] && !ctrl_r[CB_SDI];
  assign rEmpty = rGray_r == wgR2_r;
  wire pop = !rEmpty;
  // running dry is covered by skips only once the link is aligned
  wire insSkip = rEmpty && ctcOn && alignS2_r;
  wire [11:0] rWord = pop ? mem[rBin_r[FAW-1:0]] : {2'b01, 2'b00, SKIP_B};
  wire wordOk = pop || insSkip;
  wire [FAW:0] rBin_nxt = rBin_r + (FAW+1)'(1);
  assign popErr = pop && rWord[11];

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      rBin_r <= '0;
      rGray_r <= '0;
      rxPh_r <= 1'b0;
      rxData <= 20'h00000;
      rxK <= 2'b00;
      rxErr <= 2'b00;
      rxValid <= 1'b0;
    end
    else
    begin
      if (pop)
      begin
        rBin_r <= rBin_nxt;
        rGray_r <= rBin_nxt ^ (rBin_nxt >> 1);
      end
      rxValid <= wordOk && (!half || rxPh_r);
      if (wordOk)
      begin
        rxPh_r <= half && !rxPh_r;
        if (half && rxPh_r)
        begin
          rxData[19:10] <= rWord[9:0];
          rxK[1] <= rWord[10];
          rxErr[1] <= rWord[11];
        end
        else
        begin
          rxData <= {10'h000, rWord[9:0]};
          rxK <= {1'b0, rWord[10]};
          rxErr <= {1'b0, rWord[11]};
        end
      end
    end
  end

  // ********************************
  // transmit side, sys_clk is the transmit clock
  // ********************************
  logic txPh_r, txRd_r;

  wire [9:0] txSel = (half && txPh_r) ? txData[19:10] : txData[9:0];
  wire txKSel = (half && txPh_r) ? txK[1] : txK[0];
  wire txByp = ctrl_r[CB_BYP] || ctrl_r[CB_SDI];
  wire [10:0] encW = enc(txSel[7:0], txKSel, txRd_r);
  wire [9:0] txMask = ctrl_r[CB_W10] ? 10'h3ff : 10'h0ff;
  wire [9:0] txRaw = txByp ? txSel & txMask : encW[9:0];
  wire txPh_nxt = half && !txPh_r;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      txPh_r <= 1'b0;
      txRd_r <= 1'b0;
      txWord <= 10'h000;
      txReady <= 1'b0;
      txClkMon <= 1'b0;
    end
    else
    begin
      txPh_r <= txPh_nxt;
      txReady <= !half || txPh_nxt;
      if (!txByp)
        txRd_r <= encW[10];
      txWord <= (ctrl_r[CB_TXINV] ? ~txRaw : txRaw) & txMask;
      txClkMon <= ~txClkMon;
    end
  end

  // ********************************
  // checks
  // ********************************
  sequence s_ctrl_rd;
    arTake && s_axi_araddr == ADDR_CTRL ##1 s_axi_rvalid;
  endsequence

  a_write_resp: assert property (@(posedge sys_clk) disable iff (rst)
    doWrite |=> s_axi_bvalid ##0 s_axi_bresp == $past(wrMapped ?
    RESP_OKAY : RESP_DECERR)) else $error("write response wrong");
  a_ctrl_read: assert property (@(posedge sys_clk) disable iff (rst)
    s_ctrl_rd |-> s_axi_rdata[7:0] == $past(ctrl_r))
    else $error("ctrl readback wrong");
  a_lane_rate: assert property (@(posedge sys_clk) disable iff (rst)
    arTake && s_axi_araddr == ADDR_STAT |=>
    s_axi_rdata[31:16] == 16'h09c4) else $error("rate field wrong");
  a_slip_step: assert property (@(posedge rxClk) disable iff (rxRst)
    slipEv && !sdiR |=> off_r == $past(offStep))
    else $error("bit slip did not move one bit");
  a_fifo_guard: assert property (@(posedge rxClk) disable iff (rxRst)
    wFull || dropSkip |=> wBin_r == $past(wBin_r))
    else $error("write pointer moved while held");
  a_skip_insert: assert property (@(posedge sys_clk) disable iff (rst)
    insSkip && !half |=> rxValid && rxK[0]
    && rxData[7:0] == SKIP_B) else $error("skip not inserted");
  a_half_pair: assert property (@(posedge sys_clk) disable iff (rst)
    half && $past(half) && rxValid |=> !rxValid)
    else $error("half rate valid twice in a row");
  a_tx_bypass: assert property (@(posedge sys_clk) disable iff (rst)
    txByp && !half && !ctrl_r[CB_TXINV] && ctrl_r[CB_W10]
    && $stable(ctrl_r) |=> txWord == $past(txData[9:0]))
    else $error("bypass word altered");
  a_tx_clock: assert property (@(posedge sys_clk) disable iff (rst)
    !$past(rst) |-> txClkMon != $past(txClkMon))
    else $error("transmit clock monitor stalled");

endmodule

// >>> verif/spc_link_partner.sv
/*
  Far-end transmitter model: repeats comma, data, comma, data as 8b/10b
  groups on the link clock, cut at a chosen bit offset.
  Assumes the bench makes the link clock and sets offset, inversion, faults.
*/
`timescale 1ns/100ps

module spc_link_partner
(
  input wire logic lineClk,
  input wire logic [3:0] bitShift,
  input wire logic lineInv,
  input wire logic corrupt,
  output logic [9:0] wordOut
);

  // ********************************
  // symbol stream
  // ********************************
  // both comma forms alternate so running disparity stays legal
  localparam logic [9:0] SEQ [4] = '{10'h2aa, 10'h305, 10'h2aa, 10'h0fa};
  logic [1:0] symIdx_r = 2'h0;
  logic [9:0] older_r = 10'h2aa;
  logic [9:0] newer_r = 10'h0fa;
  logic [9:0] sym_nxt;
  logic [19:0] joined;

  // faults land on data slots only, so commas keep the boundary
  assign sym_nxt = (corrupt && !symIdx_r[0]) ? 10'h000
    : SEQ[symIdx_r];

  always @(posedge lineClk)
  begin
    older_r <= newer_r;
    newer_r <= sym_nxt;
    symIdx_r <= symIdx_r + 2'h1;
  end

  assign joined = {older_r, newer_r};
  assign wordOut = joined[5'd19 - bitShift -: 10] ^ {10{lineInv}};

endmodule

// >>> verif/spc_pcs_channel_tb.sv
/*
  Self-checking bench for the coding channel: registers, transmit coding,
  receive alignment, decode, polarity, slip, half rate and error flags.
  Assumes spc_link_partner feeds the receive words on the link clock.
*/
`timescale 1ns/100ps

module spc_pcs_channel_tb
  import spc_pkg::*;
;
  // ********************************
  // signals
  // ********************************
  localparam logic [7:0] TC [5] = '{8'h68, 8'h6a, 8'h0c, 8'h0e, 8'h04};
  localparam logic [9:0] TD [5] = '{10'hb5, 10'hb5, 10'h123, 10'h123, 10'h3ff};
  localparam logic [9:0] TW [5] = '{10'h2aa, 10'h155, 10'h123, 10'h2dc,
    10'hff};
  logic sys_clk, rst, rxClk, rxClkMon, txClkMon, txReady, rxValid;
  logic [9:0] rxWordIn, txWord, w1;
  logic [19:0] txData, rxData;
  logic [1:0] txK, rxK, rxErr, bresp, rresp, rsp;
  logic [3:0] awaddr, araddr, wstrb, bitShift;
  logic [31:0] wdata, rdata, rd;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, lineInv, corrupt, halfMode;
  int errorCnt, checksDone, nTot, nBad, nDat, nSkp, ch, tc, na, nb, nr;

  spc_pcs_channel uut (.sys_clk, .rst, .rxClk, .rxWordIn, .rxClkMon,
    .txClkMon, .txWord, .txData, .txK, .txReady, .rxData, .rxK, .rxErr,
    .rxValid, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));

  spc_link_partner peer (.lineClk(rxClk), .bitShift, .lineInv, .corrupt,
    .wordOut(rxWordIn));

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // odd start offset keeps the link clock out of phase with sys_clk
  initial
  begin
    rxClk = 1'b0;
    #3.7;
    forever #15 rxClk = ~rxClk;
  end

  // ********************************
  // tasks
  // ********************************
  task automatic chk(input string n, input logic [31:0] e,
    input logic [31:0] g);
    checksDone++;
    if (g !== e)
    begin
      errorCnt++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic conclude();
    if (errorCnt == 0 && checksDone > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // values read just after an edge are the ones that edge sampled
  task automatic axw(input logic [3:0] a, input logic [31:0] d,
    output logic [1:0] r);
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    fork
      begin
        do @(posedge sys_clk); while (awready !== 1'b1);
        awvalid <= 1'b0;
      end
      begin
        do @(posedge sys_clk); while (wready !== 1'b1);
        wvalid <= 1'b0;
      end
    join
    while (bvalid !== 1'b1) @(posedge sys_clk);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axr(input logic [3:0] a, output logic [31:0] d,
    output logic [1:0] r);
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge sys_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge sys_clk);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic setCtrl(input logic [7:0] c);
    axw(ADDR_CTRL, {24'h0, c}, rsp);
    chk("ctrl bresp", RESP_OKAY, rsp);
    repeat (30) @(posedge sys_clk);
  endtask

  task automatic collect(input bit raw, input int n);
    logic [9:0] w;
    logic good;
    {nTot, nBad, nDat, nSkp} = '0;
    repeat (n)
    begin
      @(posedge sys_clk);
      if (rxValid === 1'b1)
        for (int h = 0; h <= int'(halfMode); h++)
        begin
          w = rxData[h*10 +: 10];
          good = raw ? (w === 10'h0fa || w === 10'h305 || w === 10'h2aa)
            : (rxErr[h] === 1'b0 && (rxK[h] === 1'b1 ?
            (w === 10'h0bc || w === 10'h01c) :
            (rxK[h] === 1'b0 && w === 10'h0b5)));
          nTot++;
          if (!good) nBad++;
          if (w === 10'h0b5 || w === 10'h2aa) nDat++;
          if (!raw && rxK[h] === 1'b1 && w === 10'h01c) nSkp++;
        end
    end
  endtask

  // ********************************
  // tests
  // ********************************
  initial
  begin
    {rst, txData, txK, wstrb, awaddr, araddr, wdata} = {1'b1, 66'h0};
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {bitShift, lineInv, corrupt, halfMode} = {4'h3, 3'h0};
    {errorCnt, checksDone} = '0;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    axr(ADDR_CTRL, rd, rsp);
    chk("ctrl reset", 32'h68, rd);
    axr(ADDR_STAT, rd, rsp);
    chk("stat rate", 32'h09c4, rd[31:16]);
    chk("stat lanes", 32'h1, rd[10:8]);
    axr(4'h2, rd, rsp);
    chk("unmapped rresp", RESP_DECERR, rsp);
    chk("unmapped rdata", 32'h0, rd);
    axw(4'h2, 32'h1, rsp);
    chk("unmapped bresp", RESP_DECERR, rsp);
    axr(ADDR_SLIP, rd, rsp);
    chk("slip readback", 32'h0, rd);
    {ch, tc, w1} = {64'h0, 8'h00, rxClkMon, txClkMon};
    repeat (20)
    begin
      @(posedge sys_clk);
      ch += int'(rxClkMon !== w1[1]);
      tc += int'(txClkMon !== w1[0]);
      w1[1:0] = {rxClkMon, txClkMon};
    end
    chk("rx clock monitor", 1, ch >= 6 && ch <= 7);
    chk("tx clock monitor", 20, tc);
    for (int i = 0; i < 5; i++)
    begin
      setCtrl(TC[i]);
      txData <= {10'h0, TD[i]};
      repeat (3) @(posedge sys_clk);
      chk("tx word", TW[i], txWord);
    end
    axr(ADDR_CTRL, rd, rsp);
    chk("ctrl readback", 32'h04, rd);
    setCtrl(8'h68);
    txData <= 20'h000bc;
    txK <= 2'b01;
    repeat (3) @(posedge sys_clk);
    w1 = txWord;
    @(posedge sys_clk);
    chk("comma word", 1, w1 === 10'h0fa || w1 === 10'h305);
    chk("comma flip", {22'h0, ~w1}, txWord);
    setCtrl(8'h1c);
    txData <= {10'h123, 10'h0ff};
    txK <= 2'b00;
    {na, nb, nr} = '0;
    // the first edge still shows the word launched from the old data
    @(posedge sys_clk);
    repeat (8)
    begin
      @(posedge sys_clk);
      na += int'(txWord === 10'h0ff);
      nb += int'(txWord === 10'h123);
      nr += int'(txReady === 1'b1);
    end
    chk("half tx low", 4, na);
    chk("half tx high", 4, nb);
    chk("half tx ready", 4, nr);
    setCtrl(8'h68);
    collect(0, 200);
    chk("rx bad words", 0, nBad);
    chk("rx data seen", 1, nDat > 0);
    chk("rx skips added", 1, nSkp > 0);
    axr(ADDR_STAT, rd, rsp);
    chk("stat aligned", 1, rd[0]);
    lineInv <= 1'b1;
    setCtrl(8'h69);
    collect(0, 200);
    chk("inverted bad", 0, nBad);
    chk("inverted data", 1, nDat > 0);
    lineInv <= 1'b0;
    halfMode = 1'b1;
    setCtrl(8'h78);
    collect(0, 200);
    chk("half rx bad", 0, nBad);
    chk("half rx data", 1, nDat > 0);
    halfMode = 1'b0;
    setCtrl(8'h68);
    axw(ADDR_ERRS, 32'h0, rsp);
    axr(ADDR_ERRS, rd, rsp);
    chk("errs cleared", 32'h0, rd);
    corrupt <= 1'b1;
    collect(0, 100);
    chk("error flagged", 1, nBad > 0);
    corrupt <= 1'b0;
    axr(ADDR_ERRS, rd, rsp);
    chk("errs counted", 1, rd[15:0] != 16'h0);
    // auto align off keeps the boundary, so slips alone move it
    setCtrl(8'h0c);
    collect(1, 100);
    chk("raw aligned", 0, nBad);
    axw(ADDR_SLIP, 32'h1, rsp);
    repeat (30) @(posedge sys_clk);
    collect(1, 100);
    chk("one slip", 1, nTot > 0 && nBad == nTot);
    repeat (9) axw(ADDR_SLIP, 32'h1, rsp);
    repeat (30) @(posedge sys_clk);
    collect(1, 100);
    chk("ten slips", 0, nBad);
    bitShift <= 4'h0;
    setCtrl(8'h88);
    collect(1, 100);
    chk("video bad", 0, nBad);
    chk("video data", 1, nDat > 0);
    conclude();
  end

  initial
  begin
    #200000;
    errorCnt++;
    conclude();
  end

endmodule
